// ---- core/mic_pkg.sv ----
// Shared types and constants for the memory integrity checker control block
// Notes on behaviour
// - After a one-time hash ends, by success or bus error, the region takes new setup.
// - Once run-time checking is set up, one-time hashing is refused until reset.
// - Temporary checking may be disabled by software; errors raise a recoverable interrupt.
// - Permanent checking is locked; software cannot disable it.
// - Any error during permanent checking raises a security violation, not an interrupt.
// - Four independent regions; one region finishing leaves the others untouched.
// - An idle region takes new setup while other regions keep running.
// - One-time hash reports only bus errors; status tells completion from bus error.
// - Temporary checking flags only integrity or address errors, then stops that region.
// - Status shows all regions at once; any status read clears every indication (an event arriving in the read cycle stays set).
// - After a security violation the checker refuses all work until reset.
// - After a recoverable error the region returns to idle, ready for new setup.
package mic_pkg;

  localparam int unsigned MIC_REGIONS = 4;
  localparam logic MIC_FLAG_RST = 1'h0;

  typedef enum logic [1:0] {
    MIC_OP_HASH,
    MIC_OP_TEMP,
    MIC_OP_PERM
  } mic_op_t;

  typedef enum logic [1:0] {
    MIC_ST_IDLE,
    MIC_ST_HASH,
    MIC_ST_TEMP,
    MIC_ST_PERM
  } mic_state_t;

  // Per-region status word
  typedef struct packed {
    logic done;
    logic bus_err;
    logic integ_err;
    logic addr_err;
  } mic_flags_t;

  localparam mic_flags_t MIC_FLAGS_RST = '{MIC_FLAG_RST, MIC_FLAG_RST, MIC_FLAG_RST, MIC_FLAG_RST};

endpackage : mic_pkg

// ---- core/mic_region.sv ----
// One monitored memory region: mode state and its event decode
`timescale 1ns/1ps
`default_nettype none
module mic_region import mic_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire mic_op_t op_i,
  input wire logic stop_i,
  input wire logic kill_i,
  input wire logic done_i,
  input wire logic bus_err_i,
  input wire logic mismatch_i,
  input wire logic addr_err_i,
  output mic_state_t st_o,
  output logic hash_o,
  output logic check_o,
  output mic_flags_t ev_o,
  output logic perm_err_o
);

  mic_state_t st_q;
  mic_state_t st_d;
  logic any_err;

  assign any_err = bus_err_i | mismatch_i | addr_err_i;
  assign st_o = st_q;

  // Event decode; done is only meaningful for one-time hashing
  always_comb begin
    ev_o = MIC_FLAGS_RST;
    perm_err_o = 1'b0;
    case (st_q)
      MIC_ST_HASH: begin
        ev_o.bus_err = bus_err_i;
        ev_o.done = done_i & ~bus_err_i;
      end
      MIC_ST_TEMP: begin
        // Bus faults while checking count as address errors
        ev_o.integ_err = mismatch_i;
        ev_o.addr_err = addr_err_i | bus_err_i;
      end
      MIC_ST_PERM: begin
        perm_err_o = any_err;
      end
      default: begin
        ev_o = MIC_FLAGS_RST;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      MIC_ST_IDLE: begin
        if (start_i) begin
          case (op_i)
            MIC_OP_HASH: st_d = MIC_ST_HASH;
            MIC_OP_TEMP: st_d = MIC_ST_TEMP;
            MIC_OP_PERM: st_d = MIC_ST_PERM;
            default: st_d = MIC_ST_IDLE;
          endcase
        end
      end
      MIC_ST_HASH: begin
        if (done_i || bus_err_i) begin
          st_d = MIC_ST_IDLE;
        end
      end
      MIC_ST_TEMP: begin
        if (stop_i || any_err) begin
          st_d = MIC_ST_IDLE;
        end
      end
      MIC_ST_PERM: begin
        // Only a violation halts it; no software path out
        st_d = MIC_ST_PERM;
      end
      default: begin
        st_d = MIC_ST_IDLE;
      end
    endcase
    if (kill_i) begin
      st_d = MIC_ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= MIC_ST_IDLE;
      hash_o <= 1'b0;
      check_o <= 1'b0;
    end else begin
      st_q <= st_d;
      hash_o <= (st_d == MIC_ST_HASH);
      check_o <= (st_d == MIC_ST_TEMP) || (st_d == MIC_ST_PERM);
    end
  end

endmodule : mic_region
`default_nettype wire

// ---- core/mic_ctrl.sv ----
// Memory integrity checker control: setup, status, violation handling
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl import mic_pkg::*; #(
  parameter int unsigned NUM_REGIONS = MIC_REGIONS,
  localparam int unsigned IW = $clog2(NUM_REGIONS)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_valid_i,
  input wire logic [IW-1:0] cfg_region_i,
  input wire mic_op_t cfg_op_i,
  input wire logic dis_valid_i,
  input wire logic [IW-1:0] dis_region_i,
  input wire logic stat_rd_i,
  input wire logic [NUM_REGIONS-1:0] hash_done_i,
  input wire logic [NUM_REGIONS-1:0] bus_err_i,
  input wire logic [NUM_REGIONS-1:0] mismatch_i,
  input wire logic [NUM_REGIONS-1:0] addr_err_i,
  output logic [NUM_REGIONS-1:0] region_hash_o,
  output logic [NUM_REGIONS-1:0] region_check_o,
  output logic cfg_ack_o,
  output logic cfg_nak_o,
  output logic dis_ack_o,
  output logic dis_nak_o,
  output mic_flags_t [NUM_REGIONS-1:0] status_o,
  output logic irq_o,
  output logic sec_viol_o,
  output logic runtime_o
);

  if (NUM_REGIONS < 2 || NUM_REGIONS > 16) begin : g_bad_regions
    $error("mic_ctrl: NUM_REGIONS must lie in 2..16");
  end

  mic_state_t [NUM_REGIONS-1:0] st;
  mic_flags_t [NUM_REGIONS-1:0] ev;
  mic_flags_t [NUM_REGIONS-1:0] status_d;
  logic [NUM_REGIONS-1:0] start;
  logic [NUM_REGIONS-1:0] stop;
  logic [NUM_REGIONS-1:0] perm_err;
  logic cfg_ok;
  logic dis_ok;
  logic viol_set;

  // One-time hashing is a boot service only; run-time setup closes it off
  assign cfg_ok = cfg_valid_i && !sec_viol_o && (st[cfg_region_i] == MIC_ST_IDLE)
                  && !(runtime_o && cfg_op_i == MIC_OP_HASH);
  // Permanent regions are never in TEMP, so the disable cannot reach them
  assign dis_ok = dis_valid_i && !sec_viol_o && (st[dis_region_i] == MIC_ST_TEMP);
  assign viol_set = |perm_err;

  for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_region
    assign start[i] = cfg_ok && (cfg_region_i == IW'(i));
    assign stop[i] = dis_ok && (dis_region_i == IW'(i));

    mic_region u_region (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start[i]),
      .op_i(cfg_op_i),
      .stop_i(stop[i]),
      .kill_i(sec_viol_o || viol_set),
      .done_i(hash_done_i[i]),
      .bus_err_i(bus_err_i[i]),
      .mismatch_i(mismatch_i[i]),
      .addr_err_i(addr_err_i[i]),
      .st_o(st[i]),
      .hash_o(region_hash_o[i]),
      .check_o(region_check_o[i]),
      .ev_o(ev[i]),
      .perm_err_o(perm_err[i])
    );

    // A fresh event in the read cycle survives the clear
    assign status_d[i] = (stat_rd_i ? MIC_FLAGS_RST : status_o[i]) | ev[i];

    chk_region_independent: assert property (@(posedge clk_i) disable iff (rst_i)
      (st[i] == MIC_ST_TEMP) && !stop[i] && !sec_viol_o && !viol_set
      && !mismatch_i[i] && !addr_err_i[i] && !bus_err_i[i] |=> st[i] == MIC_ST_TEMP)
      else $error("region left checking without cause");

    chk_hash_reopen: assert property (@(posedge clk_i) disable iff (rst_i)
      (st[i] == MIC_ST_HASH) && (hash_done_i[i] || bus_err_i[i]) |=> st[i] == MIC_ST_IDLE)
      else $error("hash region not returned to idle");

    // An older done flag may still stand unread; the bus error must not add a new one
    chk_hash_status: assert property (@(posedge clk_i) disable iff (rst_i)
      (st[i] == MIC_ST_HASH) && bus_err_i[i] |=> status_o[i].bus_err
      && (status_o[i].done == $past(status_o[i].done && !stat_rd_i)))
      else $error("hash bus error not reported");

    chk_temp_error_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (st[i] == MIC_ST_TEMP) && mismatch_i[i] |=> status_o[i].integ_err
      && (st[i] == MIC_ST_IDLE) && !region_check_o[i])
      else $error("temporary error did not stop region");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= {NUM_REGIONS{MIC_FLAGS_RST}};
      irq_o <= 1'b0;
    end else begin
      status_o <= status_d;
      irq_o <= |status_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_viol_o <= 1'b0;
    end else if (viol_set) begin
      sec_viol_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      runtime_o <= 1'b0;
    end else if (cfg_ok && cfg_op_i != MIC_OP_HASH) begin
      runtime_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_nak_o <= 1'b0;
      dis_ack_o <= 1'b0;
      dis_nak_o <= 1'b0;
    end else begin
      cfg_ack_o <= cfg_ok;
      cfg_nak_o <= cfg_valid_i && !cfg_ok;
      dis_ack_o <= dis_ok;
      dis_nak_o <= dis_valid_i && !dis_ok;
    end
  end

  sequence s_temp_disable;
    dis_valid_i && !sec_viol_o && (st[dis_region_i] == MIC_ST_TEMP);
  endsequence

  sequence s_acked_idle;
    dis_ack_o && !irq_o ##0 !region_check_o[$past(dis_region_i)];
  endsequence

  chk_temp_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    s_temp_disable and (!stat_rd_i && !(|status_o) && (ev == '0)) |=> s_acked_idle)
    else $error("temporary disable not honoured");

  chk_perm_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    dis_valid_i && (st[dis_region_i] == MIC_ST_PERM) |=> dis_nak_o && !dis_ack_o)
    else $error("permanent region disabled");

  chk_perm_violation: assert property (@(posedge clk_i) disable iff (rst_i)
    viol_set && !stat_rd_i && !(|status_o) && (ev == '0) |=> sec_viol_o && !irq_o)
    else $error("permanent error not a violation");

  chk_runtime_no_hash: assert property (@(posedge clk_i) disable iff (rst_i)
    runtime_o |=> runtime_o ##0 (!(cfg_valid_i && cfg_op_i == MIC_OP_HASH) or ##1 cfg_nak_o))
    else $error("hash accepted in run-time mode");

  chk_idle_accept: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_valid_i && !sec_viol_o && (st[cfg_region_i] == MIC_ST_IDLE)
    && (cfg_op_i != MIC_OP_HASH) |=> cfg_ack_o
    && (region_check_o[$past(cfg_region_i)] || sec_viol_o))
    else $error("idle region refused setup");

  chk_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_rd_i && (ev == '0) |=> (status_o == '0) && !irq_o)
    else $error("status read did not clear");

  chk_viol_dead: assert property (@(posedge clk_i) disable iff (rst_i)
    sec_viol_o |=> sec_viol_o && !cfg_ack_o && (region_hash_o == '0) && (region_check_o == '0))
    else $error("checker usable after violation");

  chk_irq_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (|status_o))
    else $error("interrupt out of step with status");

endmodule : mic_ctrl
`default_nettype wire

// ---- test/mic_engine_model.sv ----
// Hashing engine model: raises one event pulse per request after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module mic_engine_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [1:0] kind_i,
  input wire logic [1:0] region_i,
  input wire logic [3:0] dly_i,
  output logic [3:0] done_o,
  output logic [3:0] bus_o,
  output logic [3:0] mism_o,
  output logic [3:0] addr_o,
  output logic busy_o
);
  logic pend_q;
  logic [3:0] cnt_q;
  logic [1:0] kind_q;
  logic [1:0] reg_q;
  assign busy_o = pend_q | go_i;
  // Events are single-cycle pulses; the lines idle low between them
  always_ff @(posedge clk_i) begin
    {done_o, bus_o, mism_o, addr_o} <= '0;
    if (rst_i) begin
      pend_q <= 1'h0;
    end else if (go_i) begin
      pend_q <= 1'h1;
      cnt_q <= dly_i;
      kind_q <= kind_i;
      reg_q <= region_i;
    end else if (pend_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (pend_q) begin
      pend_q <= 1'h0;
      case (kind_q)
        2'h0: done_o <= 4'h1 << reg_q;
        2'h1: bus_o <= 4'h1 << reg_q;
        2'h2: mism_o <= 4'h1 << reg_q;
        default: addr_o <= 4'h1 << reg_q;
      endcase
    end
  end
endmodule : mic_engine_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench for the checker control block against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_top import mic_pkg::*; ;
  logic clk_i = 0, rst_i = 1, cfg_valid_i = 0, dis_valid_i = 0, stat_rd_i = 0, go = 0;
  logic [1:0] cfg_region_i = 0, dis_region_i = 0, ekind = 0, ereg = 0;
  mic_op_t cfg_op_i = MIC_OP_HASH;
  logic [3:0] dly = 0, region_hash_o, region_check_o, hash_done_i, bus_err_i, mismatch_i, addr_err_i;
  logic cfg_ack_o, cfg_nak_o, dis_ack_o, dis_nak_o, irq_o, sec_viol_o, runtime_o, ebusy;
  mic_flags_t [3:0] status_o;
  int errors = 0, total_checks = 0, st[4];
  bit rt, viol;
  logic [15:0] stat;
  wire [31:0] gotv = {region_hash_o, region_check_o, status_o, irq_o, sec_viol_o, runtime_o, 5'h0};
  always #2 clk_i = ~clk_i;
  mic_ctrl u_mic_ctrl (.clk_i, .rst_i, .cfg_valid_i, .cfg_region_i, .cfg_op_i, .dis_valid_i,
    .dis_region_i, .stat_rd_i, .hash_done_i, .bus_err_i, .mismatch_i, .addr_err_i,
    .region_hash_o, .region_check_o, .cfg_ack_o, .cfg_nak_o, .dis_ack_o, .dis_nak_o,
    .status_o, .irq_o, .sec_viol_o, .runtime_o);
  mic_engine_model u_mic_engine_model (.clk_i, .rst_i, .go_i(go), .kind_i(ekind),
    .region_i(ereg), .dly_i(dly), .done_o(hash_done_i), .bus_o(bus_err_i),
    .mism_o(mismatch_i), .addr_o(addr_err_i), .busy_o(ebusy));
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [31:0] expv();
    logic [3:0] h, c;
    for (int i = 0; i < 4; i++) begin
      h[i] = st[i] == 1;
      c[i] = st[i] > 1;
    end
    return {h, c, stat, stat != 16'h0, viol, rt, 5'h0};
  endfunction : expv
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (15) @(posedge clk_i);
    rst_i <= 1'h0;
    st = '{default: 0};
    rt = 0;
    viol = 0;
    stat = '0;
    #1 cmp(gotv, expv());
  endtask : do_reset
  // Setup (d=0) or disable (d=1) of region r; the model decides ack or nak
  task automatic req(input bit d, input int r, input int op);
    bit ok;
    ok = !viol && (d ? st[r] == 2 : st[r] == 0 && !(rt && op == 0));
    @(posedge clk_i);
    cfg_valid_i <= !d;
    dis_valid_i <= d;
    cfg_region_i <= 2'(r);
    dis_region_i <= 2'(r);
    cfg_op_i <= mic_op_t'(op);
    @(posedge clk_i);
    cfg_valid_i <= 1'h0;
    dis_valid_i <= 1'h0;
    if (ok && d) st[r] = 0;
    if (ok && !d) st[r] = op + 1;
    if (ok && !d && op != 0) rt = 1;
    #1 cmp(d ? {dis_ack_o, dis_nak_o} : {cfg_ack_o, cfg_nak_o}, {ok, !ok});
    cmp(gotv, expv());
  endtask : req
  // Engine event k (done, bus, mismatch, address) on region r after delay w
  task automatic ev(input int r, input int k, input int w);
    int n;
    @(posedge clk_i);
    go <= 1'h1;
    ereg <= 2'(r);
    ekind <= 2'(k);
    dly <= 4'(w);
    @(posedge clk_i);
    go <= 1'h0;
    #1 n = 0;
    while (ebusy && n < 40) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 40) begin
      errors++;
      report_and_stop();
    end
    @(posedge clk_i);
    case (st[r])
      1: if (k < 2) begin stat[4*r+3-k] = 1; st[r] = 0; end
      2: if (k > 0) begin stat[4*r+(k==2)] = 1; st[r] = 0; end
      3: if (k > 0) begin viol = 1; st = '{default: 0}; end
    endcase
    #1 cmp(gotv, expv());
  endtask : ev
  task automatic rd();
    @(posedge clk_i);
    stat_rd_i <= 1'h1;
    #1 cmp(gotv, expv());
    @(posedge clk_i);
    stat_rd_i <= 1'h0;
    stat = '0;
    #1 cmp(gotv, expv());
  endtask : rd
  initial begin
    void'($urandom(7505));
    do_reset();
    req(0, 0, 0);
    req(0, 1, 0);
    req(0, 0, 0);
    ev(0, 2, 0);
    ev(0, 0, 3);
    ev(1, 1, 0);
    rd();
    req(0, 0, 0);
    req(0, 1, 0);
    $display("hash test over");
    req(0, 2, 1);
    req(0, 3, 0);
    req(1, 2, 0);
    req(1, 2, 0);
    req(0, 2, 1);
    ev(2, 0, 0);
    ev(2, 2, 5);
    req(0, 2, 1);
    ev(2, 3, 0);
    req(0, 3, 1);
    ev(3, 1, 0);
    rd();
    $display("temp test over");
    req(0, 2, 2);
    req(1, 2, 0);
    req(0, 3, 1);
    ev(2, 3, 2);
    req(0, 0, 1);
    req(1, 0, 0);
    rd();
    $display("perm test over");
    do_reset();
    repeat (80) begin
      case ($urandom_range(3))
        0: req(0, $urandom_range(3), $urandom_range(2));
        1: req(1, $urandom_range(3), 0);
        2: ev($urandom_range(3), $urandom_range(3), $urandom_range(4));
        default: rd();
      endcase
    end
    $display("random test over");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
